//--- bench/gcg_checker_assertions.sv
`timescale 1ns/1ps
`include "gcg_consts.vh"

module gcg_checker (
    input wire core_clk,
    input wire rst_b,
    input wire [`GCG_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [`GCG_NUM_SRC-1:0] src_req,
    input wire [`GCG_NUM_GEN-1:0] generator_clock_out,
    input wire [`GCG_NUM_GEN-1:0] generator_clock_pin_oe
);
    reg [3:0] en_sh;
    reg [3:0] pin_sh;
    reg [3:0] since_wr;
    wire ack_w = avs_write && !avs_waitrequest;
    wire ctl_w = ack_w && avs_address < `GCG_OFS_STATUS && avs_address[1:0] == 2'h0;

    // Shadow of enable and pin bits; only acknowledged writes count
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_sh <= 4'h0;
            pin_sh <= 4'h0;
            since_wr <= 4'hF;
        end
        else
        begin
            if (ctl_w && avs_byteenable[0])
            begin
                en_sh[avs_address[3:2]] <= avs_writedata[`GCG_BIT_EN];
                pin_sh[avs_address[3:2]] <= avs_writedata[`GCG_BIT_PIN];
            end
            since_wr <= ack_w ? 4'h0 : (since_wr == 4'hF ? since_wr : since_wr + 4'h1);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_wait_one;
        s_req |=> s_ack;
    endproperty
    property p_wait_cause;
        $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
    endproperty
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > `GCG_OFS_STATUS |-> avs_readdata == 32'h0;
    endproperty
    property p_rd_hold;
        $changed(avs_readdata) |-> $past(avs_read);
    endproperty
    // Two cycles of margin: the gate is a register behind the enable bit
    property p_gate;
        ((~en_sh & ~$past(en_sh) & ~$past(en_sh, 2)) & generator_clock_out) == 4'h0;
    endproperty
    property p_oe;
        pin_sh == $past(pin_sh) && pin_sh == $past(pin_sh, 2) |-> generator_clock_pin_oe == pin_sh;
    endproperty
    property p_oe_cause;
        $changed(generator_clock_pin_oe) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    property p_req_cause;
        (src_req & ~$past(src_req)) != 4'h0 |-> since_wr <= 4'h4;
    endproperty

    a_wait_one: assert property (p_wait_one) else $error("wait low not one cycle");
    a_wait_cause: assert property (p_wait_cause) else $error("ack without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved without read");
    a_gate: assert property (p_gate) else $error("disabled output toggles");
    a_oe: assert property (p_oe) else $error("pin enable differs from pin bit");
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
    a_req_cause: assert property (p_req_cause) else $error("request rose alone");
endmodule // gcg_checker

bind gcg_top gcg_checker i_gcg_checker (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_req(src_req),
    .generator_clock_out(generator_clock_out),
    .generator_clock_pin_oe(generator_clock_pin_oe)
);

//--- bench/gcg_osc.sv
`timescale 1ns/1ps

module gcg_osc (
    input wire core_clk,
    input wire rst_b,
    input wire [3:0] src_req,
    input wire [3:0] hold,
    output logic [3:0] src_clk,
    output logic [3:0] src_ready
);
    // Free-running oscillators; edges kept off the core sampling edge
    initial src_clk = 4'h0;
    always #20 src_clk[0] = ~src_clk[0];
    always #24 src_clk[1] = ~src_clk[1];
    always #28 src_clk[2] = ~src_clk[2];
    always #32 src_clk[3] = ~src_clk[3];

    // Ready only while requested; hold models a slow start-up
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            src_ready <= 4'h0;
        else
            src_ready <= src_req & ~hold;
    end
endmodule // gcg_osc

//--- bench/generator_clock_generator_bench.sv
`timescale 1ns/1ps

module generic_clock_generator_bench;
    logic core_clk;
    logic rst_b;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] src_clk, src_ready, src_req, hold, g_out, g_pin, g_oe;
    logic [31:0] rd;
    int num_errors = 0;
    int n_checks = 0;
    int edges;
    int hi;

    gcg_top i_gcg_top (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .src_clk(src_clk), .src_ready(src_ready), .src_req(src_req),
        .generator_clock_out(g_out), .generator_clock_pin(g_pin), .generator_clock_pin_oe(g_oe));
    gcg_osc i_gcg_osc (.core_clk(core_clk), .rst_b(rst_b), .src_req(src_req), .hold(hold),
        .src_clk(src_clk), .src_ready(src_ready));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One bus access; the request is held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    function automatic logic [31:0] ctl(int en, int duty_balance_enable, int sch, int pin, int src, int f);
        return {f[15:0], 5'h00, src[2:0], 4'h0, pin[0], sch[0], duty_balance_enable[0], en[0]};
    endfunction

    // Counts rising edges and high cycles, sampled away from the clock edge
    task automatic measure(input int g, input logic sel, input int n);
        logic prev;
        logic v;
        prev = 1'b1;
        edges = 0;
        hi = 0;
        repeat (n)
        begin
            @(negedge core_clk);
            v = sel ? g_pin[g] : g_out[g];
            hi += (v === 1'b1);
            edges += (v === 1'b1 && prev !== 1'b1);
            prev = v;
        end
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check(g_out | g_pin | g_oe | src_req, 0);
        bus(0, 5'h00, 0);
        check(rd, 0);
        bus(0, 5'h10, 0);
        check(rd, 0);
        bus(0, 5'h14, 0);
        check(rd, 0);
    endtask

    task automatic t_divide;
        int sch[6] = '{0, 0, 0, 0, 1, 1};
        int f[6] = '{0, 1, 2, 3, 0, 1};
        int d;
        for (int k = 0; k < 6; k++)
        begin
            d = sch[k] ? 2 ** (f[k] + 1) : (f[k] < 2 ? 1 : f[k]);
            bus(1, 5'h00, ctl(1, 0, sch[k], 0, 0, f[k]));
            repeat (40) @(posedge core_clk);
            measure(0, 0, 300);
            check(edges >= 30 / d - 1 && edges <= 30 / d + 1, 1);
        end
    endtask

    // Divide by 3 from a 10-cycle source, pin routed, with and without balance
    task automatic t_duty;
        for (int b = 0; b < 2; b++)
        begin
            bus(1, 5'h00, ctl(1, b, 0, 1, 0, 3));
            repeat (40) @(posedge core_clk);
            measure(0, 1, 300);
            check(g_oe[0], 1);
            check(hi >= (b ? 138 : 88) && hi <= (b ? 162 : 112), 1);
        end
        bus(1, 5'h00, ctl(0, 1, 0, 1, 0, 3));
        repeat (10) @(posedge core_clk);
        measure(0, 0, 200);
        check(hi, 0);
        measure(0, 1, 100);
        check(hi, 0);
    endtask

    // Switch from a running source to one that is slow to become ready
    task automatic t_switch;
        hold <= 4'h2;
        bus(1, 5'h00, ctl(1, 0, 0, 0, 0, 0));
        repeat (40) @(posedge core_clk);
        bus(1, 5'h00, ctl(1, 0, 0, 0, 1, 0));
        repeat (20) @(posedge core_clk);
        bus(0, 5'h10, 0);
        check({rd[10:8], rd[0]}, 4'h1);
        check(src_req[1:0], 2'h3);
        measure(0, 0, 100);
        check(edges >= 9, 1);
        hold <= 4'h0;
        repeat (20) @(posedge core_clk);
        bus(0, 5'h10, 0);
        check({rd[10:8], rd[0]}, 4'h2);
        check(src_req[1:0], 2'h2);
    endtask

    // Generator 1 feeds generator 2; generator 1 may not take itself
    task automatic t_gen1;
        bus(1, 5'h04, ctl(1, 0, 0, 0, 4, 16'hFFFF));
        bus(0, 5'h04, 0);
        check({rd[31:16], 5'h00, rd[10:8]}, 24'hFFFF00);
        bus(1, 5'h04, ctl(1, 0, 0, 0, 0, 0));
        bus(1, 5'h08, ctl(1, 0, 0, 0, 4, 16'hFFFF));
        bus(0, 5'h08, 0);
        check({rd[31:16], 5'h00, rd[10:8]}, 24'h00FF04);
        bus(1, 5'h08, ctl(1, 0, 0, 0, 4, 0));
        bus(1, 5'h0C, ctl(1, 0, 0, 0, 2, 0));
        repeat (40) @(posedge core_clk);
        bus(0, 5'h10, 0);
        check({rd[22:20], rd[18:16], rd[3:0]}, 10'h140);
        measure(2, 0, 200);
        check(edges >= 15, 1);
    endtask

    task automatic finish_test;
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        hold = 4'h0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_divide;
        t_duty;
        t_switch;
        t_gen1;
        finish_test;
    end

    // Whole run needs about 3500 cycles; cut a hang well beyond that
    initial
    begin
        #100000;
        num_errors++;
        finish_test;
    end
endmodule // generic_clock_generator_bench

//--- verilog/gcg_consts.vh
// ----------------------------------------------------------------------------
// Notes on behaviour
// RQ1: Writing enable 1 starts the output clock
// RQ2: Enable 0 holds the output low, gated
// RQ3: Each generator has its own source select
// RQ4: Keep old source until new reports ready
// RQ5: Request both sources while a switch runs; code requests the old source only while the enable bit is set
// RQ6: Sync pending reads 1 until switch done
// RQ7: Only generator 1 may feed other generators
// RQ8: Divide source by factor per scheme bit
// RQ9: Scheme 0, factor 0 or 1: undivided
// RQ10: Factor field width set per generator
// RQ11: Duty balance gives 50/50 on odd divisors
// RQ12: Output clock can drive an external pin
// RQ13: Scheme 0, factor two or more: divide by factor
// RQ14: Scheme 1: divide by two to factor plus one; code divides by two to 31 for any factor above 30
// ----------------------------------------------------------------------------
`ifndef GCG_CONSTS_VH
`define GCG_CONSTS_VH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define GCG_NUM_GEN 4
`define GCG_NUM_SRC 4
`define GCG_SRC_W 3
`define GCG_SRC_GEN1 3'h4
`define GCG_COMMON_GEN 1
`define GCG_ADDR_W 5
`define GCG_DIV_W_MAX 16
`define GCG_DIV_W_COMMON 16
`define GCG_DIV_W_OTHER 8

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define GCG_OFS_CTRL0 5'h00
`define GCG_OFS_STRIDE 4
`define GCG_OFS_STATUS 5'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define GCG_BIT_EN 0
`define GCG_BIT_IDC 1
`define GCG_BIT_SCHEME 2
`define GCG_BIT_PIN 3
`define GCG_SRC_LSB 8
`define GCG_DIV_LSB 16

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define GCG_STAT_PEND_LSB 0
`define GCG_STAT_CUR_LSB 8
`define GCG_STAT_CUR_STRIDE 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GCG_CTRL_RST 32'h00000000
`define GCG_SRC_RST 3'h0

`endif

//--- verilog/gcg_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Two-flop synchroniser, one chain per bit
// ----------------------------------------------------------------------------
module gcg_sync #(
    parameter WIDTH = 4
) (
    input wire core_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // gcg_sync

//--- verilog/gcg_top.v
`timescale 1ns/1ps
`include "gcg_consts.vh"

module gcg_top (
    input wire core_clk,
    input wire rst_b,
    input wire [`GCG_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [`GCG_NUM_SRC-1:0] src_clk,
    input wire [`GCG_NUM_SRC-1:0] src_ready,
    output reg [`GCG_NUM_SRC-1:0] src_req,
    output wire [`GCG_NUM_GEN-1:0] generator_clock_out,
    output wire [`GCG_NUM_GEN-1:0] generator_clock_pin,
    output wire [`GCG_NUM_GEN-1:0] generator_clock_pin_oe
);

    // ------------------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------------------
    wire [`GCG_NUM_SRC-1:0] src_clk_s;
    wire [`GCG_NUM_SRC-1:0] src_ready_s;

    // Source clocks are sampled, so they must run well below core_clk / 2
    gcg_sync #(
        .WIDTH(2 * `GCG_NUM_SRC)
    ) u_src_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({src_ready, src_clk}),
        .sync_out({src_ready_s, src_clk_s})
    );

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    wire wr_ok;
    wire [31:0] be_mask;
    wire [32*`GCG_NUM_GEN-1:0] ctrl_flat;
    wire [`GCG_NUM_GEN-1:0] pend_flat;
    wire [`GCG_SRC_W*`GCG_NUM_GEN-1:0] cur_flat;
    wire [`GCG_NUM_SRC*`GCG_NUM_GEN-1:0] req_flat;
    wire [`GCG_NUM_GEN-1:0] out_flat;
    reg [31:0] rd_word;
    reg [31:0] status_word;
    reg [`GCG_NUM_SRC-1:0] next_src_req;
    integer i;

    // A write lands on the edge where the master sees waitrequest low
    assign wr_ok = avs_write & ~avs_waitrequest;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Status word gathers pending flags and active sources
    always @*
    begin
        status_word = 32'h00000000;
        for (i = 0; i < `GCG_NUM_GEN; i = i + 1)
        begin
            status_word[`GCG_STAT_PEND_LSB + i] = pend_flat[i]; // [RQ6]
            status_word[`GCG_STAT_CUR_LSB + `GCG_STAT_CUR_STRIDE * i +: `GCG_SRC_W] =
                cur_flat[`GCG_SRC_W * i +: `GCG_SRC_W];
        end
    end

    // Read mux; unmapped addresses return zero
    always @*
    begin
        rd_word = 32'h00000000;
        for (i = 0; i < `GCG_NUM_GEN; i = i + 1)
        begin
            if (avs_address == (`GCG_OFS_CTRL0 + i * `GCG_OFS_STRIDE))
            begin
                rd_word = ctrl_flat[32 * i +: 32];
            end
        end
        if (avs_address == `GCG_OFS_STATUS)
        begin
            rd_word = status_word;
        end
    end

    // One wait cycle per access, then a one-cycle acknowledge
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            if ((avs_read | avs_write) & avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
            end
            else
            begin
                avs_waitrequest <= 1'b1;
            end
            if (avs_read & avs_waitrequest)
            begin
                avs_readdata <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Source requests, merged over all generators
    // ------------------------------------------------------------------------
    always @*
    begin
        next_src_req = {`GCG_NUM_SRC{1'b0}};
        for (i = 0; i < `GCG_NUM_GEN; i = i + 1)
        begin
            next_src_req = next_src_req | req_flat[`GCG_NUM_SRC * i +: `GCG_NUM_SRC];
        end
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_req <= {`GCG_NUM_SRC{1'b0}};
        end
        else
        begin
            src_req <= next_src_req;
        end
    end

    // ------------------------------------------------------------------------
    // Generator channels
    // ------------------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < `GCG_NUM_GEN; n = n + 1)
        begin : g_gen
            // Field width differs per channel; the common feeder is wider
            localparam integer DIV_W = (n == `GCG_COMMON_GEN) ?
                `GCG_DIV_W_COMMON : `GCG_DIV_W_OTHER;
            localparam [`GCG_DIV_W_MAX-1:0] FMASK =
                {`GCG_DIV_W_MAX{1'b1}} >> (`GCG_DIV_W_MAX - DIV_W); // [RQ10]
            localparam integer MY_OFS = `GCG_OFS_CTRL0 + n * `GCG_OFS_STRIDE;

            reg [31:0] ctrl;
            reg [`GCG_SRC_W-1:0] cur;
            reg pend;
            reg src_prev;
            reg [32:0] phase;
            reg out_q;
            reg pin_q;
            reg pin_oe_q;
            reg [32:0] next_phase;
            reg next_out;

            wire en = ctrl[`GCG_BIT_EN];
            wire duty_balance_enable = ctrl[`GCG_BIT_IDC];
            wire scheme = ctrl[`GCG_BIT_SCHEME];
            wire pin_en = ctrl[`GCG_BIT_PIN];
            wire [`GCG_SRC_W-1:0] sel = ctrl[`GCG_SRC_LSB +: `GCG_SRC_W];
            wire [`GCG_DIV_W_MAX-1:0] fac = ctrl[`GCG_DIV_LSB +: `GCG_DIV_W_MAX];

            // Register write for this channel
            wire wr_hit = wr_ok & (avs_address == MY_OFS[`GCG_ADDR_W-1:0]);
            wire [31:0] merged = (ctrl & ~be_mask) | (avs_writedata & be_mask);
            wire [`GCG_SRC_W-1:0] wsrc = merged[`GCG_SRC_LSB +: `GCG_SRC_W];
            // Generator 1 output is the only internal source, never for itself
            wire wsrc_ok = (wsrc < `GCG_NUM_SRC) |
                ((wsrc == `GCG_SRC_GEN1) & (n != `GCG_COMMON_GEN)); // [RQ7]
            wire [`GCG_SRC_W-1:0] src_eff = wsrc_ok ? wsrc : sel; // [RQ3]
            wire [31:0] next_ctrl = {merged[31:16] & FMASK, 5'h00, src_eff,
                                     4'h0, merged[3:0]};

            // Readiness and level of the selected and the active source
            wire sel_rdy = (sel < `GCG_NUM_SRC) ? src_ready_s[sel[1:0]] :
                ctrl_flat[32 * `GCG_COMMON_GEN + `GCG_BIT_EN];
            wire src_lvl = (cur < `GCG_NUM_SRC) ? src_clk_s[cur[1:0]] :
                out_flat[`GCG_COMMON_GEN]; // [RQ7]

            // Switch only once the new source reports ready
            wire do_switch = pend & (sel != cur) & sel_rdy; // [RQ4]
            wire pend_set = wr_hit & (src_eff != cur);
            wire pend_done = pend & ((sel == cur) | sel_rdy);

            // Divisor from factor and scheme
            wire [4:0] shamt = (fac > 16'h001E) ? 5'h1F : (fac[4:0] + 5'h01);
            wire [31:0] div_d = scheme ? (32'h00000001 << shamt) : // [RQ14]
                ((fac < 16'h0002) ? 32'h00000001 : {16'h0000, fac}); // [RQ8] [RQ13]
            wire [32:0] period = {div_d, 1'b0};
            // High time in source half-periods; odd without balance is short
            wire [32:0] high_t = (duty_balance_enable | ~div_d[0]) ? {1'b0, div_d} :
                ({1'b0, div_d} - 33'h000000001); // [RQ11]
            wire half_edge = src_lvl ^ src_prev;

            // Half-period counter and output level
            always @*
            begin
                next_phase = phase;
                if (!en || do_switch)
                begin
                    next_phase = 33'h000000000;
                end
                else if (half_edge)
                begin
                    if (phase >= period - 33'h000000001)
                    begin
                        next_phase = 33'h000000000;
                    end
                    else
                    begin
                        next_phase = phase + 33'h000000001;
                    end
                end
                if (!en)
                begin
                    next_out = 1'b0; // [RQ2]
                end
                else if (div_d == 32'h00000001)
                begin
                    next_out = src_lvl; // [RQ9]
                end
                else
                begin
                    next_out = (next_phase < high_t); // [RQ1] [RQ8]
                end
            end

            // Control register, switch state and pending flag
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    ctrl <= `GCG_CTRL_RST;
                    cur <= `GCG_SRC_RST;
                    pend <= 1'b0;
                end
                else
                begin
                    if (wr_hit)
                    begin
                        ctrl <= next_ctrl; // [RQ1]
                    end
                    if (do_switch)
                    begin
                        cur <= sel; // [RQ4]
                    end
                    // A new request in the finishing cycle keeps the flag set
                    if (pend_set)
                    begin
                        pend <= 1'b1; // [RQ6]
                    end
                    else if (pend_done)
                    begin
                        pend <= 1'b0; // [RQ6]
                    end
                end
            end

            // Divider state and output flops
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    src_prev <= 1'b0;
                    phase <= 33'h000000000;
                    out_q <= 1'b0;
                    pin_q <= 1'b0;
                    pin_oe_q <= 1'b0;
                end
                else
                begin
                    src_prev <= src_lvl;
                    phase <= next_phase;
                    out_q <= next_out;
                    pin_q <= next_out & pin_en; // [RQ12]
                    pin_oe_q <= pin_en; // [RQ12]
                end
            end

            // Old source is held by cur until the switch only while enabled, new one by pend
            assign req_flat[`GCG_NUM_SRC * n +: `GCG_NUM_SRC] =
                (((en & (cur < `GCG_NUM_SRC)) ? 4'h1 : 4'h0) << cur[1:0]) |
                (((pend & (sel < `GCG_NUM_SRC)) ? 4'h1 : 4'h0) << sel[1:0]); // [RQ5]

            assign ctrl_flat[32 * n +: 32] = ctrl;
            assign pend_flat[n] = pend;
            assign cur_flat[`GCG_SRC_W * n +: `GCG_SRC_W] = cur;
            assign out_flat[n] = out_q;
            assign generator_clock_out[n] = out_q;
            assign generator_clock_pin[n] = pin_q;
            assign generator_clock_pin_oe[n] = pin_oe_q;
        end
    endgenerate

endmodule // gcg_top
